// ---- dv/dpm_dram_model.sv ----
// Far-side model of the DRAM banks and board wiring on the shared pins
`timescale 1ns/100ps
module dpm_dram_model (
    input wire logic [dpm_pkg::NPIN-1:0] pin_out_in,
    input wire logic [dpm_pkg::NPIN-1:0] pin_oe_n_in,
    input wire logic [dpm_pkg::NPIN-1:0] ext_en_in,
    input wire logic [dpm_pkg::NPIN-1:0] ext_val_in,
    output logic [dpm_pkg::NPIN-1:0] pin_level_out,
    output logic clash_out
);
    // Released lines take the board driver's value where it is enabled, else float to the board pull-up
    always_comb begin
        for (int i = 0; i < dpm_pkg::NPIN; i++) begin
            pin_level_out[i] = !pin_oe_n_in[i] ? pin_out_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
        end
    end
    // Device and board both driving one pin
    assign clash_out = |(~pin_oe_n_in & ext_en_in);
endmodule : dpm_dram_model

// ---- dv/test_dram_pin_and_port_mux.sv ----
// Self-checking bench for the DRAM pin and port multiplexer
`timescale 1ns/100ps
module test_dram_pin_and_port_mux;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, chk = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, req2, int2, clash;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    dpm_pkg::dpm_periph_s periph = '0;
    logic [11:0] pin_in, pin_out, pin_oe_n, ext_en = 12'h000, ext_val = 12'h000;
    logic [11:0] ctl_m = 12'h000, po_m = 12'h000, pd_m = 12'h000;
    logic [31:0] seed = 32'h57ea14fe;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [26:0] pq[$];

    always #5 mclk_in = ~mclk_in;

    dpm_pin_mux u_dpm_pin_mux (.mclk_in(mclk_in), .rstn_in(rstn_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .periph_in(periph), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n),
        .dma2_request_in_out(req2), .int2_request_out(int2));

    dpm_dram_model u_dpm_dram_model (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_level_out(pin_in), .clash_out(clash));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Expected {clash, req2, int2, oe_n, out} from current settings
    function automatic logic [26:0] exp_pins(input dpm_pkg::dpm_periph_s p);
        logic [11:0] pe, pv, d, o, lvl;
        logic dual, one;
        dual = ctl_m[0] & ~ctl_m[1];
        one = ctl_m[0] & ctl_m[1];
        pe = {ctl_m[7], ctl_m[6], {4{ctl_m[3]}}, {4{ctl_m[2]}}, ctl_m[4], ctl_m[5]};
        pe[6] = ctl_m[3] | ctl_m[8];
        pe[8] = ctl_m[3] | ctl_m[9];
        pv[0] = p.csel5_n;
        pv[1] = p.bus_clk;
        pv[2] = p.ras4_n;
        pv[3] = (dual & p.addr0) | p.cas4_n;
        pv[4] = one ? (p.addr0 | p.we4_n) : ((dual & ~p.addr0) | p.cas4_n);
        pv[5] = one ? (~p.addr0 | p.we4_n) : p.we4_n;
        pv[6] = ctl_m[3] ? p.ras5_n : p.end2;
        pv[7] = (dual & p.addr0) | p.cas5_n;
        pv[8] = !ctl_m[3] ? p.ack2 : one ? (p.addr0 | p.we5_n) : ((dual & ~p.addr0) | p.cas5_n);
        pv[9] = one ? (~p.addr0 | p.we5_n) : p.we5_n;
        pv[10] = p.uclk1;
        pv[11] = p.ack0;
        d = pe | pd_m;
        d[7] = d[7] & ~ctl_m[10];
        d[10] = d[10] & ~ctl_m[11];
        o = d & ((pe & pv) | (~pe & po_m));
        lvl = (d & o) | (~d & (~ext_en | ext_val));
        return {1'b0, ctl_m[10] & lvl[7], ctl_m[11] & lvl[10], ~d, o};
    endfunction : exp_pins

    task automatic check(input string name, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge mclk_in);
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bvalid) begin
            @(posedge mclk_in);
            if (awready && !aw_d) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_d) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        @(posedge mclk_in);
        rq.push_back({er, ed});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rvalid) begin
            @(posedge mclk_in);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_read

    task automatic pins;
        @(posedge mclk_in);
        pq.push_back(exp_pins(periph));
        chk <= 1'b1;
        @(posedge mclk_in);
        chk <= 1'b0;
    endtask : pins

    // Result watcher: oldest note against each answer
    always @(posedge mclk_in) begin
        if (bvalid && bready && bq.size() > 0) check("bresp", bq.pop_front(), bresp);
        if (rvalid && rready && rq.size() > 0) check("rdata", rq.pop_front(), {rresp, rdata});
        if (chk && pq.size() > 0) check("pins", pq.pop_front(), {clash, req2, int2, pin_oe_n, pin_out});
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge mclk_in);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        axi_read(dpm_pkg::ADDR_PIN_CTRL, dpm_pkg::RESP_OKAY, 32'h00000000);
        axi_read(dpm_pkg::ADDR_PORT_DIR, dpm_pkg::RESP_OKAY, 32'h00000000);
        axi_read(dpm_pkg::ADDR_PIN_OE, dpm_pkg::RESP_OKAY, 32'h00000000);
        axi_read(dpm_pkg::ADDR_PIN_IN, dpm_pkg::RESP_OKAY, 32'h00000fff);
        pins();
        axi_read(8'h14, dpm_pkg::RESP_SLVERR, 32'h00000000);
        axi_write(dpm_pkg::ADDR_PIN_IN, 32'hffffffff, dpm_pkg::RESP_SLVERR);
        axi_write(dpm_pkg::ADDR_PIN_OE, 32'hffffffff, dpm_pkg::RESP_SLVERR);
        axi_write(8'h3c, 32'hffffffff, dpm_pkg::RESP_SLVERR);
        seed = lfsr(seed);
        po_m = seed[11:0];
        pd_m = 12'hfff;
        axi_write(dpm_pkg::ADDR_PORT_OUT, seed, dpm_pkg::RESP_OKAY);
        axi_write(dpm_pkg::ADDR_PORT_DIR, 32'hffffffff, dpm_pkg::RESP_OKAY);
        pins();
        axi_read(dpm_pkg::ADDR_PORT_OUT, dpm_pkg::RESP_OKAY, {20'h00000, po_m});
        axi_read(dpm_pkg::ADDR_PIN_IN, dpm_pkg::RESP_OKAY, {20'h00000, po_m});
        // 8-bit, dual column strobe, single column strobe
        for (int m = 0; m < 3; m++) begin
            ctl_m = 12'h0fc | ((m == 0) ? 12'h000 : (m == 1) ? 12'h001 : 12'h003);
            axi_write(dpm_pkg::ADDR_PIN_CTRL, {20'hfffff, ctl_m}, dpm_pkg::RESP_OKAY);
            axi_read(dpm_pkg::ADDR_PIN_CTRL, dpm_pkg::RESP_OKAY, {20'h00000, ctl_m});
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                periph <= {seed[12:7], i[0], seed[5:0]};
                pins();
            end
        end
        // Area 5 off: shared DMA channel 2 outputs and port bit
        ctl_m = 12'h3f5;
        seed = lfsr(seed);
        po_m = seed[11:0];
        axi_write(dpm_pkg::ADDR_PORT_OUT, seed, dpm_pkg::RESP_OKAY);
        axi_write(dpm_pkg::ADDR_PIN_CTRL, {20'h00000, ctl_m}, dpm_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            periph <= seed[12:0];
            pins();
        end
        // Request inputs release their pins
        ctl_m = 12'hffd;
        axi_write(dpm_pkg::ADDR_PIN_CTRL, {20'h00000, ctl_m}, dpm_pkg::RESP_OKAY);
        ext_en <= 12'h480;
        for (int v = 0; v < 2; v++) begin
            seed = lfsr(seed);
            ext_val <= {12{v[0]}};
            periph <= seed[12:0];
            pins();
        end
        axi_read(dpm_pkg::ADDR_PIN_OE, dpm_pkg::RESP_OKAY, 32'h00000b7f);
        test_done();
    end
endmodule : test_dram_pin_and_port_mux

// ---- verilog/dpm_pin_mux.sv ----
// Pin multiplexer for DRAM strobes, chip select, bus clock and DMA/UART pins
// How it works
// [R1] Active peripheral output always overrides the port output on a pin.
// [R2] Bank0 row strobe pin carries area 4 RAS in every mode, else port.
// [R3] Bank1 row strobe pin carries area 5 RAS; port only if RAS, end of transfer unused.
// [R4] 16-bit dual-CAS: low column strobe only for byte lane address bit 0.
// [R5] 16-bit dual-CAS: high column strobe only for byte lane address bit 1.
// [R6] 16-bit single-CAS: cas_high pins are low-byte write enables.
// [R7] 16-bit single-CAS: write enable pins are high-byte write enables.
// [R8] Bank0 cas_low: single CAS in 8-bit, low-byte CAS in dual-CAS.
// [R9] Bank0 cas_high: also CAS in 8-bit, high-byte CAS in dual-CAS.
// [R10] Bank0 write enable is active-low area 4 WE in dual-CAS and 8-bit.
// [R11] Bank1 write enable is active-low area 5 WE likewise.
// [R12] Bank1 CAS pins mirror bank0, shared with DMA2 request/acknowledge.
// [R13] Bus clock pin outputs bus clock when enabled, else port bit.
// [R14] Chip select five is active low, else port bit.
// [R15] UART1 clock pin drives UART1 clock only when clock output enabled, else port bit.
// [R16] DMA0 acknowledge drives only when enabled, else port bit.
// [R17] Bank1 row strobe pin is port only when RAS and end of transfer both unused.
// [R18] Pins used as request/interrupt inputs have all outputs disabled.
`timescale 1ns/100ps
module dpm_pin_mux (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire dpm_pkg::dpm_periph_s periph_in,
    input wire logic [dpm_pkg::NPIN-1:0] pin_in,
    output logic [dpm_pkg::NPIN-1:0] pin_out,
    output logic [dpm_pkg::NPIN-1:0] pin_oe_n_out,
    output logic dma2_request_in_out,
    output logic int2_request_out
);
    dpm_pkg::dpm_state_s s_q;
    dpm_pkg::dpm_state_s s_d;
    logic [dpm_pkg::NPIN-1:0] fn_en;
    logic [dpm_pkg::NPIN-1:0] fn_val;
    logic [dpm_pkg::NPIN-1:0] drv;
    logic [dpm_pkg::NPIN-1:0] val;
    logic bus16;
    logic one_cas;
    logic lo_lane;
    logic hi_lane;
    logic req2_sel;
    logic int2_sel;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign bus16 = s_q.ctl[dpm_pkg::CTL_BUS16];
    assign one_cas = s_q.ctl[dpm_pkg::CTL_ONE_CAS];
    assign req2_sel = s_q.ctl[dpm_pkg::CTL_REQ2_EN];
    assign int2_sel = s_q.ctl[dpm_pkg::CTL_INT2_EN];
    // [R4] Lane selection by address bit
    assign lo_lane = !bus16 || !periph_in.addr0;
    // [R5] High lane only for address bit one
    assign hi_lane = !bus16 || periph_in.addr0;

    always_comb begin
        fn_en = '0;
        fn_val = '1;
        // [R14] Chip select five, active low
        fn_en[dpm_pkg::PIN_CSEL5] = s_q.ctl[dpm_pkg::CTL_CSEL5_EN];
        fn_val[dpm_pkg::PIN_CSEL5] = periph_in.csel5_n;
        // [R13] Bus clock output
        fn_en[dpm_pkg::PIN_CLK] = s_q.ctl[dpm_pkg::CTL_CLK_EN];
        fn_val[dpm_pkg::PIN_CLK] = periph_in.bus_clk;
        // [R2] Area 4 row strobe
        fn_en[dpm_pkg::PIN_ROW0] = s_q.ctl[dpm_pkg::CTL_DRAM4_EN];
        fn_val[dpm_pkg::PIN_ROW0] = periph_in.ras4_n;
        // [R3] Area 5 row strobe or end of transfer
        fn_en[dpm_pkg::PIN_ROW1] = s_q.ctl[dpm_pkg::CTL_DRAM5_EN] || s_q.ctl[dpm_pkg::CTL_END2_EN];
        fn_val[dpm_pkg::PIN_ROW1] = s_q.ctl[dpm_pkg::CTL_DRAM5_EN] ? periph_in.ras5_n : periph_in.end2;
        // [R8] Area 4 low or single column strobe
        fn_en[dpm_pkg::PIN_CAS0L] = s_q.ctl[dpm_pkg::CTL_DRAM4_EN];
        fn_val[dpm_pkg::PIN_CAS0L] = periph_in.cas4_n || (!one_cas && !lo_lane);
        fn_en[dpm_pkg::PIN_CAS0H] = s_q.ctl[dpm_pkg::CTL_DRAM4_EN];
        fn_en[dpm_pkg::PIN_WE0] = s_q.ctl[dpm_pkg::CTL_DRAM4_EN];
        // [R12] Area 5 column strobes, else DMA2 functions
        fn_en[dpm_pkg::PIN_CAS1L] = s_q.ctl[dpm_pkg::CTL_DRAM5_EN];
        fn_val[dpm_pkg::PIN_CAS1L] = periph_in.cas5_n || (!one_cas && !lo_lane);
        fn_en[dpm_pkg::PIN_CAS1H] = s_q.ctl[dpm_pkg::CTL_DRAM5_EN] || s_q.ctl[dpm_pkg::CTL_ACK2_EN];
        fn_en[dpm_pkg::PIN_WE1] = s_q.ctl[dpm_pkg::CTL_DRAM5_EN];
        if (bus16 && one_cas) begin
            // [R6] High CAS pins become low-byte write enables
            fn_val[dpm_pkg::PIN_CAS0H] = periph_in.we4_n || periph_in.addr0;
            fn_val[dpm_pkg::PIN_CAS1H] = periph_in.we5_n || periph_in.addr0;
            // [R7] Write enable pins become high-byte write enables
            fn_val[dpm_pkg::PIN_WE0] = periph_in.we4_n || !periph_in.addr0;
            fn_val[dpm_pkg::PIN_WE1] = periph_in.we5_n || !periph_in.addr0;
        end else begin
            // [R9] Area 4 high or shared column strobe
            fn_val[dpm_pkg::PIN_CAS0H] = periph_in.cas4_n || !hi_lane;
            fn_val[dpm_pkg::PIN_CAS1H] = periph_in.cas5_n || !hi_lane;
            // [R10] Area 4 active-low write enable
            fn_val[dpm_pkg::PIN_WE0] = periph_in.we4_n;
            // [R11] Area 5 active-low write enable
            fn_val[dpm_pkg::PIN_WE1] = periph_in.we5_n;
        end
        if (!s_q.ctl[dpm_pkg::CTL_DRAM5_EN]) begin
            fn_val[dpm_pkg::PIN_CAS1H] = periph_in.ack2;
        end
        // [R15] UART1 clock output
        fn_en[dpm_pkg::PIN_UCLK1] = s_q.ctl[dpm_pkg::CTL_UCLK1_EN];
        fn_val[dpm_pkg::PIN_UCLK1] = periph_in.uclk1;
        // [R16] DMA0 acknowledge
        fn_en[dpm_pkg::PIN_ACK0] = s_q.ctl[dpm_pkg::CTL_ACK0_EN];
        fn_val[dpm_pkg::PIN_ACK0] = periph_in.ack0;
    end

    for (genvar g = 0; g < dpm_pkg::NPIN; g++) begin : g_pin
        logic in_only;
        // [R18] Request and interrupt inputs block all drive
        assign in_only = (g == dpm_pkg::PIN_CAS1L && req2_sel) || (g == dpm_pkg::PIN_UCLK1 && int2_sel);
        // [R1] Peripheral wins over port
        // [R17] Port on bank1 row pin only when both functions off
        assign drv[g] = !in_only && (fn_en[g] || s_q.port_dir[g]);
        assign val[g] = fn_en[g] ? fn_val[g] : s_q.port_out[g];
    end

    assign pin_out = val & drv;
    assign pin_oe_n_out = ~drv;
    assign dma2_request_in_out = req2_sel && pin_in[dpm_pkg::PIN_CAS1L];
    assign int2_request_out = int2_sel && pin_in[dpm_pkg::PIN_UCLK1];

    always_comb begin
        logic [31:0] wv;
        logic [7:0] a;
        s_d = s_q;
        wv = '0;
        a = '0;
        unique case (s_q.state)
            dpm_pkg::BS_IDLE: begin
                if (s_axi_awvalid_in && !s_q.aw_got) begin
                    s_d.aw_got = 1'b1;
                    s_d.awaddr = s_axi_awaddr_in;
                end
                if (s_axi_wvalid_in && !s_q.w_got) begin
                    s_d.w_got = 1'b1;
                    s_d.wdata = s_axi_wdata_in;
                    s_d.wstrb = s_axi_wstrb_in;
                end
                if (s_q.aw_got && s_q.w_got) begin
                    s_d.aw_got = 1'b0;
                    s_d.w_got = 1'b0;
                    s_d.resp = dpm_pkg::RESP_OKAY;
                    s_d.state = dpm_pkg::BS_WRESP;
                    unique case (s_q.awaddr)
                        dpm_pkg::ADDR_PIN_CTRL: begin
                            wv = merge({20'h00000, s_q.ctl}, s_q.wdata, s_q.wstrb);
                            s_d.ctl = wv[dpm_pkg::CTL_WIDTH-1:0];
                        end
                        dpm_pkg::ADDR_PORT_OUT: begin
                            wv = merge({20'h00000, s_q.port_out}, s_q.wdata, s_q.wstrb);
                            s_d.port_out = wv[dpm_pkg::NPIN-1:0];
                        end
                        dpm_pkg::ADDR_PORT_DIR: begin
                            wv = merge({20'h00000, s_q.port_dir}, s_q.wdata, s_q.wstrb);
                            s_d.port_dir = wv[dpm_pkg::NPIN-1:0];
                        end
                        default: s_d.resp = dpm_pkg::RESP_SLVERR;
                    endcase
                end else if (s_axi_arvalid_in && s_axi_arready_out) begin
                    a = s_axi_araddr_in;
                    s_d.state = dpm_pkg::BS_RRESP;
                    s_d.resp = dpm_pkg::RESP_OKAY;
                    unique case (a)
                        dpm_pkg::ADDR_PIN_CTRL: s_d.rdata = {20'h00000, s_q.ctl};
                        dpm_pkg::ADDR_PORT_OUT: s_d.rdata = {20'h00000, s_q.port_out};
                        dpm_pkg::ADDR_PORT_DIR: s_d.rdata = {20'h00000, s_q.port_dir};
                        dpm_pkg::ADDR_PIN_IN: s_d.rdata = {20'h00000, pin_in};
                        dpm_pkg::ADDR_PIN_OE: s_d.rdata = {20'h00000, drv};
                        default: begin
                            s_d.rdata = '0;
                            s_d.resp = dpm_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            dpm_pkg::BS_WRESP: begin
                if (s_axi_bready_in) begin
                    s_d.state = dpm_pkg::BS_IDLE;
                end
            end
            dpm_pkg::BS_RRESP: begin
                if (s_axi_rready_in) begin
                    s_d.state = dpm_pkg::BS_IDLE;
                end
            end
            default: s_d.state = dpm_pkg::BS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            s_q <= '0;
            s_q.ctl <= dpm_pkg::CTL_RESET;
            s_q.port_out[7:0] <= dpm_pkg::PORT_RESET;
            s_q.state <= dpm_pkg::BS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_out = (s_q.state == dpm_pkg::BS_IDLE) && !s_q.aw_got;
    assign s_axi_wready_out = (s_q.state == dpm_pkg::BS_IDLE) && !s_q.w_got;
    assign s_axi_arready_out = (s_q.state == dpm_pkg::BS_IDLE) && !s_q.aw_got && !s_q.w_got
        && !(s_axi_awvalid_in || s_axi_wvalid_in);
    assign s_axi_bvalid_out = s_q.state == dpm_pkg::BS_WRESP;
    assign s_axi_bresp_out = s_q.resp;
    assign s_axi_rvalid_out = s_q.state == dpm_pkg::BS_RRESP;
    assign s_axi_rresp_out = s_q.resp;
    assign s_axi_rdata_out = s_q.rdata;

    // Assertions
    peri_wins_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R1]
        fn_en[dpm_pkg::PIN_ROW0]
        |-> (pin_out[dpm_pkg::PIN_ROW0] == periph_in.ras4_n && !pin_oe_n_out[dpm_pkg::PIN_ROW0]))
        else $error("row strobe 0 not driven by peripheral");
    row1_port_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R17]
        (!s_q.ctl[dpm_pkg::CTL_DRAM5_EN] && !s_q.ctl[dpm_pkg::CTL_END2_EN])
        |-> pin_out[dpm_pkg::PIN_ROW1] == (s_q.port_out[dpm_pkg::PIN_ROW1] && s_q.port_dir[dpm_pkg::PIN_ROW1]))
        else $error("row strobe 1 pin not port");
    row0_port_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R2]
        !s_q.ctl[dpm_pkg::CTL_DRAM4_EN]
        |-> pin_out[dpm_pkg::PIN_ROW0] == (s_q.port_out[dpm_pkg::PIN_ROW0] && s_q.port_dir[dpm_pkg::PIN_ROW0]))
        else $error("row strobe 0 pin not port");
    row1_func_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R3]
        s_q.ctl[dpm_pkg::CTL_DRAM5_EN] |-> pin_out[dpm_pkg::PIN_ROW1] == periph_in.ras5_n)
        else $error("row strobe 1 not from area 5");
    cas0l_byte8_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R8]
        (fn_en[dpm_pkg::PIN_CAS0L] && !bus16) |-> pin_out[dpm_pkg::PIN_CAS0L] == periph_in.cas4_n)
        else $error("low cas wrong in 8-bit mode");
    cas0h_byte8_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R9]
        (fn_en[dpm_pkg::PIN_CAS0H] && !bus16) |-> pin_out[dpm_pkg::PIN_CAS0H] == periph_in.cas4_n)
        else $error("high cas wrong in 8-bit mode");
    we0_plain_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R10]
        (fn_en[dpm_pkg::PIN_WE0] && !(bus16 && one_cas)) |-> pin_out[dpm_pkg::PIN_WE0] == periph_in.we4_n)
        else $error("area 4 write enable wrong");
    we1_plain_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R11]
        (fn_en[dpm_pkg::PIN_WE1] && !(bus16 && one_cas)) |-> pin_out[dpm_pkg::PIN_WE1] == periph_in.we5_n)
        else $error("area 5 write enable wrong");
    cas1h_lane_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R12]
        (s_q.ctl[dpm_pkg::CTL_DRAM5_EN] && bus16 && !one_cas && periph_in.addr0)
        |-> pin_out[dpm_pkg::PIN_CAS1H] == periph_in.cas5_n)
        else $error("area 5 high cas wrong");
    bus_clk_out_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R13]
        s_q.ctl[dpm_pkg::CTL_CLK_EN] |-> pin_out[dpm_pkg::PIN_CLK] == periph_in.bus_clk)
        else $error("bus clock pin wrong");
    csel5_out_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R14]
        s_q.ctl[dpm_pkg::CTL_CSEL5_EN] |-> pin_out[dpm_pkg::PIN_CSEL5] == periph_in.csel5_n)
        else $error("chip select five pin wrong");
    ack0_gate_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R16]
        (!s_q.ctl[dpm_pkg::CTL_ACK0_EN] && !s_q.port_dir[dpm_pkg::PIN_ACK0]) |-> pin_oe_n_out[dpm_pkg::PIN_ACK0])
        else $error("acknowledge pin driven while disabled");
    lo_cas_lane_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R4]
        (fn_en[dpm_pkg::PIN_CAS0L] && bus16 && !one_cas && periph_in.addr0) |-> pin_out[dpm_pkg::PIN_CAS0L])
        else $error("low cas on odd lane");
    hi_cas_lane_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R5]
        (fn_en[dpm_pkg::PIN_CAS0H] && bus16 && !one_cas && !periph_in.addr0) |-> pin_out[dpm_pkg::PIN_CAS0H])
        else $error("high cas on even lane");
    lo_we_map_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R6]
        (fn_en[dpm_pkg::PIN_CAS0H] && bus16 && one_cas) |->
        pin_out[dpm_pkg::PIN_CAS0H] == (periph_in.we4_n || periph_in.addr0))
        else $error("low byte write enable wrong");
    hi_we_map_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R7]
        (fn_en[dpm_pkg::PIN_WE1] && bus16 && one_cas) |->
        pin_out[dpm_pkg::PIN_WE1] == (periph_in.we5_n || !periph_in.addr0))
        else $error("high byte write enable wrong");
    input_nodrive_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R18]
        req2_sel |-> pin_oe_n_out[dpm_pkg::PIN_CAS1L])
        else $error("request input pin driven");
    uclk_gate_a: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R15]
        (!s_q.ctl[dpm_pkg::CTL_UCLK1_EN] && !s_q.port_dir[dpm_pkg::PIN_UCLK1]) |-> pin_oe_n_out[dpm_pkg::PIN_UCLK1])
        else $error("uart clock pin driven while disabled");
    wr_resp_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (s_q.aw_got && s_q.w_got) |=> s_axi_bvalid_out)
        else $error("write response late");
endmodule : dpm_pin_mux

// ---- verilog/dpm_pkg.sv ----
// Package for the DRAM pin and port multiplexer: register map, fields, types
package dpm_pkg;
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PORT_OUT = 8'h04;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h08;
    localparam logic [7:0] ADDR_PIN_IN = 8'h0c;
    localparam logic [7:0] ADDR_PIN_OE = 8'h10;
    // Pin control field positions
    localparam int CTL_BUS16 = 0;
    localparam int CTL_ONE_CAS = 1;
    localparam int CTL_DRAM4_EN = 2;
    localparam int CTL_DRAM5_EN = 3;
    localparam int CTL_CLK_EN = 4;
    localparam int CTL_CSEL5_EN = 5;
    localparam int CTL_UCLK1_EN = 6;
    localparam int CTL_ACK0_EN = 7;
    localparam int CTL_END2_EN = 8;
    localparam int CTL_ACK2_EN = 9;
    localparam int CTL_REQ2_EN = 10;
    localparam int CTL_INT2_EN = 11;
    localparam int CTL_WIDTH = 12;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 12'h000;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Pin indices of the bundle
    localparam int PIN_CSEL5 = 0;
    localparam int PIN_CLK = 1;
    localparam int PIN_ROW0 = 2;
    localparam int PIN_CAS0L = 3;
    localparam int PIN_CAS0H = 4;
    localparam int PIN_WE0 = 5;
    localparam int PIN_ROW1 = 6;
    localparam int PIN_CAS1L = 7;
    localparam int PIN_CAS1H = 8;
    localparam int PIN_WE1 = 9;
    localparam int PIN_UCLK1 = 10;
    localparam int PIN_ACK0 = 11;
    localparam int NPIN = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_WRESP = 2'b01,
        BS_RRESP = 2'b10
    } dpm_bus_e;

    // Peripheral signals as they appear at pins; strobes named _n are active low
    typedef struct packed {
        logic ras4_n;
        logic ras5_n;
        logic cas4_n;
        logic cas5_n;
        logic we4_n;
        logic we5_n;
        logic addr0;
        logic bus_clk;
        logic csel5_n;
        logic uclk1;
        logic ack0;
        logic end2;
        logic ack2;
    } dpm_periph_s;

    typedef struct packed {
        dpm_bus_e state;
        logic [CTL_WIDTH-1:0] ctl;
        logic [NPIN-1:0] port_out;
        logic [NPIN-1:0] port_dir;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
        logic [1:0] resp;
    } dpm_state_s;
endpackage : dpm_pkg
